/* hdl/prl_top.sv */
// Peer reference link: master sender, slave scaling, loss and runaway guard
`timescale 1ns/1ps
`include "prl_cfg.svh"
module prl_top #(
  parameter int TICK_CYCLES = `PRL_TICK_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic peer_link_enable,
  input wire logic peer_role_select,
  input wire logic slave_follow_run_select,
  input wire logic received_data_usage,
  input wire logic signed [15:0] torque_rx_offset,
  input wire logic signed [15:0] torque_rx_gain,
  input wire logic [6:0] link_loss_timeout,
  input wire logic [13:0] master_send_period,
  input wire logic signed [15:0] freq_rx_offset,
  input wire logic signed [15:0] freq_rx_gain,
  input wire logic [13:0] runaway_guard_coeff,
  input wire logic [1:0] run_command_source,
  input wire logic [15:0] max_output_frequency,
  input wire logic [2:0] link_bit_rate,
  input wire logic speed_torque_control_select,
  input wire logic [2:0] torque_source_select,
  input wire logic freq_source_is_comm,
  input wire logic signed [15:0] local_ref,
  input wire logic local_run,
  input wire logic signed [15:0] speed_fb,
  input wire logic signed [15:0] speed_expect,
  input wire logic runaway_clear,
  input wire logic rx_valid,
  input wire logic [16:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [16:0] tx_data,
  output logic [7:0] node_addr,
  output logic [2:0] link_rate_out,
  output logic signed [15:0] torque_ref_out,
  output logic [15:0] freq_ref_out,
  output logic torque_ref_valid,
  output logic freq_ref_valid,
  output logic follow_run_cmd,
  output logic link_loss_fault,
  output logic runaway_trip
);
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg; // 1 ms divider
  logic tick_reg; // One-cycle 1 ms enable
  logic [13:0] period_cnt_reg; // Ms since last send
  logic tx_pend_reg; // Frame waiting for FIFO room
  logic [16:0] tx_word_reg; // Frame held while pending
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [16:0] fifo_out_data;
  logic [13:0] loss_cnt_reg; // Ms since last receive
  logic [13:0] loss_lim; // Timeout in ms
  prl_pkg::prl_link_e link_reg; // Supervision state
  logic is_master;
  logic is_slave;
  logic use_trq;
  logic use_frq;
  logic guard_on;
  logic signed [31:0] x_val;
  logic signed [31:0] y_trq;
  logic signed [31:0] y_frq;
  logic signed [31:0] speed_err;
  logic signed [31:0] guard_band; // Coefficient as a positive signed band

  assign is_master = peer_link_enable && (peer_role_select == `PRL_ROLE_MASTER);
  assign is_slave = peer_link_enable && (peer_role_select == `PRL_ROLE_SLAVE);
  // usage only when matching source is communication
  assign use_trq = is_slave && (received_data_usage == `PRL_USE_TORQUE)
                   && (torque_source_select == `PRL_TRQ_SRC_COMM);
  assign use_frq = is_slave && (received_data_usage == `PRL_USE_FREQ)
                   && freq_source_is_comm;
  assign guard_on = use_trq && (speed_torque_control_select == `PRL_CTRL_TORQUE)
                    && (runaway_guard_coeff != 14'h0);
  // received value is signed 0.01 % steps
  assign x_val = 32'(signed'(rx_data[15:0]));
  // Timeout in 0.1 s steps turned into 1 ms ticks
  assign loss_lim = 14'(link_loss_timeout * `PRL_TMO_UNIT_MS);
  assign speed_err = 32'(speed_fb) - 32'(speed_expect);
  // Band kept signed: an unsigned compare would trip on every negative error
  assign guard_band = 32'(signed'({1'b0, runaway_guard_coeff}));

  // y = k*x + b for torque and frequency, clamped
  assign y_trq = scale(x_val, torque_rx_gain, torque_rx_offset);
  assign y_frq = scale(x_val, freq_rx_gain, freq_rx_offset);

  // Gain in 0.01 units, so the product is divided back by 100
  function automatic logic signed [31:0] scale(
    input logic signed [31:0] x,
    input logic signed [15:0] k,
    input logic signed [15:0] b
  );
    logic signed [31:0] y;
    y = (x * 32'(k)) / `PRL_GAIN_ONE + 32'(b);
    if (y > `PRL_FULL_SCALE) begin
      y = `PRL_FULL_SCALE;
    end else if (y < -`PRL_FULL_SCALE) begin
      y = -`PRL_FULL_SCALE;
    end
    return y;
  endfunction

  // 1 ms tick divider, free running so tick spacing stays exact
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == ($bits(tick_cnt_reg))'(TICK_CYCLES - 1)) begin
      // Wrap and fire the 1 ms enable
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // Static outputs: address and rate
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      node_addr <= `PRL_ADDR_MASTER;
      link_rate_out <= 3'h0;
    end else begin
      node_addr <= peer_role_select ? `PRL_ADDR_SLAVE : `PRL_ADDR_MASTER;
      link_rate_out <= link_bit_rate;
    end
  end

  // Master send timing; a full FIFO holds the newest frame pending, a later send period overwrites it
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !is_master) begin
      period_cnt_reg <= 14'h0;
      tx_pend_reg <= 1'b0;
      tx_word_reg <= 17'h0;
    end else begin
      // FIFO took the pending frame
      if (tx_pend_reg && fifo_in_ready) begin
        tx_pend_reg <= 1'b0;
      end
      if (tick_reg) begin
        // one frame per send period, zero read as 1 ms
        if (period_cnt_reg + 14'h1 >= master_send_period) begin
          period_cnt_reg <= 14'h0;
          // own run and reference sent out
          tx_word_reg <= {local_run, local_ref};
          tx_pend_reg <= 1'b1;
        end else begin
          period_cnt_reg <= period_cnt_reg + 14'h1;
        end
      end
    end
  end

  // Outgoing frame buffer toward the link
  prl_fifo #(
    .W(17),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(tx_pend_reg),
    .in_ready(fifo_in_ready),
    .in_data(tx_word_reg),
    .out_valid(fifo_out_valid),
    .out_ready(tx_ready),
    .out_data(fifo_out_data)
  );
  // Link side sees the FIFO head directly, no extra cycle of delay
  assign tx_valid = fifo_out_valid;
  assign tx_data = fifo_out_data;

  // Link supervision on the slave
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !is_slave) begin
      loss_cnt_reg <= 14'h0;
      link_reg <= prl_pkg::PRL_LNK_IDLE;
    end else if (rx_valid) begin
      loss_cnt_reg <= 14'h0;
      link_reg <= prl_pkg::PRL_LNK_OK;
    end else begin
      if (tick_reg && loss_cnt_reg != 14'h3fff) begin
        loss_cnt_reg <= loss_cnt_reg + 14'h1;
      end
      unique case (link_reg)
        prl_pkg::PRL_LNK_IDLE,
        prl_pkg::PRL_LNK_OK: begin
          if (loss_lim != 14'h0 && loss_cnt_reg >= loss_lim) begin
            link_reg <= prl_pkg::PRL_LNK_LOST;
          end
        end
        prl_pkg::PRL_LNK_LOST: begin
          // Stays lost until fresh data arrives
          link_reg <= prl_pkg::PRL_LNK_LOST;
        end
        default: begin
          link_reg <= prl_pkg::PRL_LNK_IDLE;
        end
      endcase
    end
  end

  // Fault flag as a register for software
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link_loss_fault <= 1'b0;
    end else begin
      link_loss_fault <= (link_reg == prl_pkg::PRL_LNK_LOST) && !rx_valid && is_slave;
    end
  end

  // Slave torque reference
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !use_trq || runaway_trip) begin
      torque_ref_out <= 16'sh0;
      torque_ref_valid <= 1'b0;
    end else if (rx_valid) begin
      // 100.00 % received gives 200.00 % torque
      torque_ref_out <= 16'(y_trq * `PRL_TORQUE_MUL);
      torque_ref_valid <= 1'b1;
    end else if (link_reg == prl_pkg::PRL_LNK_LOST) begin
      torque_ref_out <= 16'sh0;
      torque_ref_valid <= 1'b0;
    end
  end

  // Slave frequency reference, magnitude of max frequency share
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !use_frq) begin
      freq_ref_out <= 16'h0;
      freq_ref_valid <= 1'b0;
    end else if (rx_valid) begin
      // full scale gives max output frequency
      freq_ref_out <= 16'(((y_frq < 0 ? -y_frq : y_frq) * 32'(max_output_frequency))
                          / `PRL_FULL_SCALE);
      freq_ref_valid <= 1'b1;
    end else if (link_reg == prl_pkg::PRL_LNK_LOST) begin
      freq_ref_out <= 16'h0;
      freq_ref_valid <= 1'b0;
    end
  end

  // Run following; a lost link commands stop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      follow_run_cmd <= 1'b0;
    end else if (!(is_slave && slave_follow_run_select
                   && run_command_source == `PRL_CMD_SRC_COMM)) begin
      follow_run_cmd <= 1'b0;
    end else if (rx_valid) begin
      follow_run_cmd <= rx_data[16];
    end else if (link_reg == prl_pkg::PRL_LNK_LOST) begin
      // A dead link commands stop
      follow_run_cmd <= 1'b0;
    end
  end

  // Runaway trip: speed drifting beyond the coefficient band while sharing torque
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      runaway_trip <= 1'b0;
    end else if (guard_on && (speed_err > guard_band || speed_err < -guard_band)) begin
      // detection sets trip, set beats clear
      runaway_trip <= 1'b1;
    end else if (runaway_clear || !guard_on) begin
      runaway_trip <= 1'b0;
    end
  end
endmodule

/* hdl/prl_cfg.svh */
// Constants for the peer reference link: addresses, codes, scales and timing
`ifndef PRL_CFG_SVH
`define PRL_CFG_SVH
// Automatic node addresses per role
`define PRL_ADDR_MASTER 8'h01
`define PRL_ADDR_SLAVE 8'h02
// Setting codes
`define PRL_ROLE_MASTER 1'b0
`define PRL_ROLE_SLAVE 1'b1
`define PRL_USE_TORQUE 1'b0
`define PRL_USE_FREQ 1'b1
`define PRL_CMD_SRC_COMM 2'h2
`define PRL_TRQ_SRC_COMM 3'h5
`define PRL_CTRL_TORQUE 1'b1
// Full scale of 100.00 % in 0.01 % steps, and 1.00 gain in 0.01 steps
`define PRL_FULL_SCALE 32'sd10000
`define PRL_GAIN_ONE 32'sd100
// Torque full scale maps to 200.0 % rated torque
`define PRL_TORQUE_MUL 32'sd2
// Timeout setting unit 0.1 s in ms ticks
`define PRL_TMO_UNIT_MS 14'd100
// Defaults of the settings
`define PRL_TMO_DEFAULT 7'd10
`define PRL_PERIOD_DEFAULT 14'd1
`define PRL_RUNAWAY_DEFAULT 14'd1000
`define PRL_GAIN_DEFAULT 16'sd100
`define PRL_OFFSET_DEFAULT 16'sd0
// Tick base: 1 ms at a 10 ns clock
`define PRL_TICK_NS 1000000
`define PRL_CLK_NS 10
`define PRL_TICK_CYCLES (`PRL_TICK_NS / `PRL_CLK_NS)
`endif

/* hdl/prl_pkg.sv */
// Types for the peer reference link
package prl_pkg;
  // Link supervision state, one-hot
  typedef enum logic [2:0] {
    PRL_LNK_IDLE = 3'b001,
    PRL_LNK_OK = 3'b010,
    PRL_LNK_LOST = 3'b100
  } prl_link_e;
endpackage

/* hdl/prl_fifo.sv */
// Small valid/ready FIFO for outgoing reference frames
`timescale 1ns/1ps
module prl_fifo #(
  parameter int W = 17,
  parameter int D = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D]; // Storage words
  logic [AW-1:0] wr_ptr_reg; // Write index
  logic [AW-1:0] rd_ptr_reg; // Read index
  logic [AW:0] cnt_reg; // Fill level
  logic push;
  logic pop;

  // Flags from the fill level; full is compared at the counter's own width,
  // since a power-of-two depth would wrap to zero in the narrower index width
  assign in_ready = (cnt_reg != (AW + 1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write, no reset needed for data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      // Simultaneous push and pop keep the level
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

/* testbench/prl_peer_model.sv */
// Peer drive model on the far side of the reference link
`timescale 1ns/1ps
module prl_peer_model (
  input wire logic clk_sys,
  input wire logic stall,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [16:0] tx_data,
  output logic rx_valid,
  output logic [16:0] rx_data
);
  // Frames taken from the block, and the newest of them
  int rx_count = 0;
  logic [16:0] last_frame = 17'h00000;
  initial begin
    rx_valid = 1'b0;
    rx_data = 17'h00000;
  end
  // Ready drops while stalled, so the block has to hold its frames
  assign tx_ready = !stall;
  // A frame counts only at an edge where valid and ready meet
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      rx_count <= rx_count + 1;
      last_frame <= tx_data;
    end
  end
  // One-cycle frame; the data line is inverted after it, never left holding
  // run bit and signed reference
  task automatic send(input logic [16:0] frame);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_data <= frame;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_data <= ~frame;
  endtask
endmodule

/* testbench/prl_top_chk.sv */
// Port checker for the peer reference link
`timescale 1ns/1ps
module prl_top_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic peer_link_enable,
  input wire logic peer_role_select,
  input wire logic slave_follow_run_select,
  input wire logic [13:0] runaway_guard_coeff,
  input wire logic [1:0] run_command_source,
  input wire logic [2:0] link_bit_rate,
  input wire logic speed_torque_control_select,
  input wire logic rx_valid,
  input wire logic [16:0] rx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [16:0] tx_data,
  input wire logic [7:0] node_addr,
  input wire logic [2:0] link_rate_out,
  input wire logic torque_ref_valid,
  input wire logic freq_ref_valid,
  input wire logic follow_run_cmd,
  input wire logic link_loss_fault,
  input wire logic runaway_trip
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Slave frame that must be followed
  sequence follow_rx_s;
    rx_valid && peer_link_enable && peer_role_select && slave_follow_run_select
      && run_command_source == 2'h2;
  endsequence
  // Two cycles where following is not allowed; the drop may take one register
  sequence no_follow_s;
    (rst_n && !(peer_role_select && slave_follow_run_select
      && run_command_source == 2'h2))[*2];
  endsequence
  rate_copy_a: assert property (rst_n |=> link_rate_out == $past(link_bit_rate))
    else $error("Link rate output differs from setting");
  node_role_a: assert property (rst_n && peer_link_enable |=>
    node_addr == ($past(peer_role_select) ? 8'h02 : 8'h01))
    else $error("Node address does not follow role");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("Frame changed before it was taken");
  link_off_a: assert property ((rst_n && !peer_link_enable)[*2] |->
    !torque_ref_valid && !freq_ref_valid && !follow_run_cmd)
    else $error("Reference active while link disabled");
  follow_take_a: assert property (follow_rx_s |=> follow_run_cmd == $past(rx_data[16]))
    else $error("Run command not taken from frame");
  follow_gate_a: assert property (no_follow_s |-> !follow_run_cmd)
    else $error("Run command followed without permission");
  loss_drop_a: assert property (link_loss_fault |->
    !torque_ref_valid && !freq_ref_valid && !follow_run_cmd)
    else $error("Stale reference kept during link loss");
  guard_off_a: assert property ((rst_n && (runaway_guard_coeff == 14'h0000
    || !speed_torque_control_select))[*2] |-> !runaway_trip)
    else $error("Runaway trip while guard inactive");
endmodule
bind prl_top prl_top_chk prl_top_chk_inst (.*);

/* testbench/prl_top_tb.sv */
// Self-checking bench for the peer reference link
`timescale 1ns/1ps
module prl_top_tb;
  // Clock, reset and one-bit settings
  logic clk_sys = 1'b0, rst_n = 1'b0, peer_link_enable = 1'b0, peer_role_select = 1'b0;
  logic slave_follow_run_select = 1'b1, received_data_usage = 1'b0, local_run = 1'b1;
  logic speed_torque_control_select = 1'b1, freq_source_is_comm = 1'b1;
  logic runaway_clear = 1'b0, stall = 1'b1;
  // Values in 0.01 steps; gain 100 means 1.00
  logic signed [15:0] torque_rx_offset = 16'sh0000, torque_rx_gain = 16'sh0064;
  logic signed [15:0] freq_rx_offset = 16'sh0000, freq_rx_gain = 16'sh0064;
  logic signed [15:0] local_ref = 16'sh1234, speed_fb = 16'sh0000, speed_expect = 16'sh0000;
  logic [6:0] link_loss_timeout = 7'h01;
  logic [13:0] master_send_period = 14'h0002, runaway_guard_coeff = 14'h0000;
  logic [1:0] run_command_source = 2'h2;
  logic [15:0] max_output_frequency = 16'h1388;
  logic [2:0] link_bit_rate = 3'h5, torque_source_select = 3'h5;
  // Link side and outputs
  logic rx_valid, tx_valid, tx_ready, torque_ref_valid, freq_ref_valid;
  logic follow_run_cmd, link_loss_fault, runaway_trip;
  logic [16:0] rx_data, tx_data;
  logic [7:0] node_addr;
  logic [2:0] link_rate_out;
  logic signed [15:0] torque_ref_out;
  logic [15:0] freq_ref_out;
  int num_errors = 0, cmp_count = 0, n, y;
  // Received value, gain, offset; two cases overrange on purpose
  int xs[4] = '{10000, 5000, 8000, -10000};
  int ks[4] = '{100, -200, 300, 100};
  int bs[4] = '{0, 100, 0, -5000};
  // Short tick keeps periods and timeouts cheap
  prl_top #(.TICK_CYCLES(10)) prl_top_inst (.*);
  prl_peer_model prl_peer_model_inst (.*);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  // Compare and count
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Linear scaling with the plus/minus full-scale clamp
  function automatic int scale(input int x, input int k, input int b);
    int v;
    v = k * x / 100 + b;
    return (v > 10000) ? 10000 : ((v < -10000) ? -10000 : v);
  endfunction
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    step(4);
    rst_n <= 1'b1;
    step(2);
    chk(17'(node_addr), 17'h00001);
    chk(17'(link_rate_out), 17'h00005);
    // Master with the far side stalled until the FIFO refuses
    peer_link_enable <= 1'b1;
    step(150);
    chk(17'(prl_peer_model_inst.rx_count), 17'h00000);
    stall <= 1'b0;
    local_ref <= 16'shd8f0;
    local_run <= 1'b0;
    step(100);
    chk(prl_peer_model_inst.last_frame, 17'h0d8f0);
    n = prl_peer_model_inst.rx_count;
    step(200);
    chk(17'(prl_peer_model_inst.rx_count - n), 17'h0000a);
    peer_link_enable <= 1'b0;
    step(20);
    n = prl_peer_model_inst.rx_count;
    step(100);
    chk(17'(prl_peer_model_inst.rx_count - n), 17'h00000);
    // Slave: torque half then frequency half; the idle pair gets gain zero
    peer_role_select <= 1'b1;
    peer_link_enable <= 1'b1;
    step(2);
    chk(17'(node_addr), 17'h00002);
    for (int i = 0; i < 8; i++) begin
      received_data_usage <= i[2];
      torque_rx_gain <= i[2] ? 16'sh0000 : 16'(ks[i % 4]);
      torque_rx_offset <= i[2] ? 16'sh0000 : 16'(bs[i % 4]);
      freq_rx_gain <= i[2] ? 16'(ks[i % 4]) : 16'sh0000;
      freq_rx_offset <= i[2] ? 16'(bs[i % 4]) : 16'sh0000;
      prl_peer_model_inst.send({1'b1, 16'(xs[i % 4])});
      step(1);
      y = scale(xs[i % 4], ks[i % 4], bs[i % 4]);
      if (i < 4) begin
        chk({1'b0, torque_ref_out}, {1'b0, 16'(2 * y)});
      end else begin
        chk({1'b0, freq_ref_out}, 17'((y < 0 ? -y : y) * 5000 / 10000));
      end
      chk({torque_ref_valid, freq_ref_valid}, {!i[2], i[2]});
      chk(17'(follow_run_cmd), 17'h00001);
    end
    // Frequency source off communication: received data is not applied
    freq_source_is_comm <= 1'b0;
    prl_peer_model_inst.send(17'h11388);
    step(1);
    chk(17'(freq_ref_valid), 17'h00000);
    freq_source_is_comm <= 1'b1;
    slave_follow_run_select <= 1'b0;
    prl_peer_model_inst.send(17'h10000);
    step(1);
    chk(17'(follow_run_cmd), 17'h00000);
    // Silence for one tenth of a second of ticks
    n = 0;
    while (link_loss_fault !== 1'b1 && n < 1500) begin
      step(1);
      n++;
    end
    chk(17'(n >= 980 && n <= 1020), 17'h00001);
    if (n == 1500) tally_and_finish();
    chk(17'(freq_ref_valid), 17'h00000);
    prl_peer_model_inst.send(17'h01388);
    step(1);
    chk({link_loss_fault, freq_ref_valid}, 17'h00001);
    link_loss_timeout <= 7'h00;
    step(1500);
    chk(17'(link_loss_fault), 17'h00000);
    // Runaway: trip, clear, then guard off by coefficient and by mode
    received_data_usage <= 1'b0;
    torque_rx_gain <= 16'sh0064;
    runaway_guard_coeff <= 14'h03e8;
    speed_fb <= 16'sh0bb8;
    prl_peer_model_inst.send(17'h02710);
    step(2);
    chk({runaway_trip, torque_ref_out}, 17'h10000);
    speed_fb <= 16'sh0000;
    runaway_clear <= 1'b1;
    step(1);
    runaway_clear <= 1'b0;
    step(1);
    chk(17'(runaway_trip), 17'h00000);
    speed_fb <= 16'shf448;
    step(2);
    chk(17'(runaway_trip), 17'h00001);
    speed_fb <= 16'sh0bb8;
    runaway_guard_coeff <= 14'h0000;
    step(3);
    chk(17'(runaway_trip), 17'h00000);
    runaway_guard_coeff <= 14'h03e8;
    speed_torque_control_select <= 1'b0;
    step(3);
    chk(17'(runaway_trip), 17'h00000);
    tally_and_finish();
  end
endmodule
